// ### rtl/spc_defs.vh
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH
`define SPC_ADDR_W 8
`define SPC_OFF_SUPPLY 8'h10
`define SPC_OFF_CLKPM 8'h20
`define SPC_OFF_IRQ_STATUS 8'h30
`define SPC_OFF_IRQ_MASK 8'h34
`define SPC_OFF_CARD_LIMIT 8'h38
`define SPC_SUP_FIXED_ONE 10
`define SPC_SUP_STOP_POLICY 7
`define SPC_SUP_CORE_LSB 4
`define SPC_SUP_PROG_LSB 0
`define SPC_PM_ACCESS_SEEN 25
`define SPC_PM_FREQ_CHANGED 24
`define SPC_PM_CTL_ENABLE 16
`define SPC_PM_ACTION 0
`define SPC_V_OFF 3'h0
`define SPC_V_12 3'h1
`define SPC_V_5 3'h2
`define SPC_V_3V3 3'h3
`define SPC_V_XX 3'h4
`define SPC_V_YY 3'h5
`define SPC_IRQ_ACCESS 0
`define SPC_IRQ_FREQ 1
`define SPC_IRQ_SUPPLY 2
`define SPC_IRQ_W 3
`define SPC_SLOW_DIV 16
`endif

// ### rtl/spc_sync.v
`timescale 1ns/1ps
module spc_sync #(
  parameter W = 1
) (
  input wire CLOCK,
  input wire RST,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      always @(posedge CLOCK) begin
        if (RST) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
        end
      end
      assign q[i] = s2_reg;
    end
  endgenerate
endmodule

// ### rtl/spc_volt_gate.v
`timescale 1ns/1ps
`include "spc_defs.vh"
module spc_volt_gate (
  input wire card_present,
  input wire [3:0] card_ok,
  input wire [2:0] core_req,
  input wire [2:0] prog_req,
  output reg [2:0] core_out,
  output reg [2:0] prog_out
);
  // card_ok: {yy, xx, 3v3, 5v}; 12 V programming is always allowed
  function allowed;
    input [2:0] code;
    input [3:0] ok;
    input prog;
    begin
      case (code)
        `SPC_V_OFF: allowed = 1'b1;
        `SPC_V_12: allowed = prog;
        `SPC_V_5: allowed = ok[0];
        `SPC_V_3V3: allowed = ok[1];
        `SPC_V_XX: allowed = prog & ok[2];
        `SPC_V_YY: allowed = ok[3];
        default: allowed = 1'b0;
      endcase
    end
  endfunction
  always @* begin
    core_out = core_req;
    prog_out = prog_req;
    if (!card_present || !allowed(core_req, card_ok, 1'b0)) begin
      core_out = `SPC_V_OFF;
    end
    if (!card_present || !allowed(prog_req, card_ok, 1'b1)) begin
      prog_out = `SPC_V_OFF;
    end
  end
endmodule

// ### rtl/spc_socket_power_clock_ctrl.v
`timescale 1ns/1ps
`include "spc_defs.vh"
// How it works
// - Supply reg: bit10 one, reserved zero
// - Policy bit7 stops clock ignoring host
// - Core supply field bits 6-4 encoding
// - Programming supply field bits 2-0 encoding
// - Power only voltages the card accepts, except 12 V programming
// - Supply fields survive host reset when PME
// - Access seen bit sets, read clears
// - Freq changed bit shows slowed clock
// - Enable bit16 gates idle clock control
// - Bit0 picks stop or divide by 16
// - Status bits cleared by global reset only
// - Power management reserved bits read zero
module spc_socket_power_clock_ctrl (
  CLOCK,
  RST,
  HOST_BUS_RESET,
  PME_ENABLE,
  ADDR,
  WDATA,
  WR,
  RD,
  RDATA,
  CARD_PRESENT,
  CARD_VOLT_OK,
  CARD_ACCESS,
  CARD_IDLE,
  HOST_CLKRUN_STOPPING,
  CORE_SUPPLY,
  PROG_SUPPLY,
  SUPPLY_UPDATE,
  CARD_CLK_STOP_REQ,
  CARD_CLK_SLOW_REQ,
  CARD_CLK_EN,
  IRQ
);
  input wire CLOCK;
  input wire RST;
  input wire HOST_BUS_RESET;
  input wire PME_ENABLE;
  input wire [`SPC_ADDR_W-1:0] ADDR;
  input wire [31:0] WDATA;
  input wire WR;
  input wire RD;
  output reg [31:0] RDATA;
  input wire CARD_PRESENT;
  input wire [3:0] CARD_VOLT_OK;
  input wire CARD_ACCESS;
  input wire CARD_IDLE;
  input wire HOST_CLKRUN_STOPPING;
  output reg [2:0] CORE_SUPPLY;
  output reg [2:0] PROG_SUPPLY;
  output reg SUPPLY_UPDATE;
  output reg CARD_CLK_STOP_REQ;
  output reg CARD_CLK_SLOW_REQ;
  output reg CARD_CLK_EN;
  output reg IRQ;

  wire [5:0] pin_in;
  wire [5:0] pin_s;
  wire present_s;
  wire [3:0] ok_s;
  wire access_s;
  wire idle_s;
  wire host_stop_s;
  wire hbr_s;
  wire pme_s;
  assign pin_in = {HOST_BUS_RESET, PME_ENABLE, HOST_CLKRUN_STOPPING, CARD_IDLE,
                   CARD_ACCESS, CARD_PRESENT};
  spc_sync #(.W(6)) u_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .d(pin_in),
    .q(pin_s)
  );
  spc_sync #(.W(4)) u_sync_ok (
    .CLOCK(CLOCK),
    .RST(RST),
    .d(CARD_VOLT_OK),
    .q(ok_s)
  );
  assign hbr_s = pin_s[5];
  assign pme_s = pin_s[4];
  assign host_stop_s = pin_s[3];
  assign idle_s = pin_s[2];
  assign access_s = pin_s[1];
  assign present_s = pin_s[0];

  reg stop_policy_reg;
  reg [2:0] core_req_reg;
  reg [2:0] prog_req_reg;
  reg ctl_enable_reg;
  reg action_reg;
  reg access_seen_reg;
  reg freq_changed_reg;
  reg [`SPC_IRQ_W-1:0] irq_status_reg;
  reg [`SPC_IRQ_W-1:0] irq_mask_reg;
  reg [2:0] core_app_reg;
  reg [2:0] prog_app_reg;
  reg [3:0] div_reg;
  wire [2:0] core_ok;
  wire [2:0] prog_ok;
  wire wr_sup;
  wire wr_pm;
  wire rd_pm;
  wire host_rst_hits_ctx;
  wire [`SPC_IRQ_W-1:0] irq_events;

  spc_volt_gate u_gate (
    .card_present(present_s),
    .card_ok(ok_s),
    .core_req(core_req_reg),
    .prog_req(prog_req_reg),
    .core_out(core_ok),
    .prog_out(prog_ok)
  );

  assign wr_sup = WR && (ADDR == `SPC_OFF_SUPPLY);
  assign wr_pm = WR && (ADDR == `SPC_OFF_CLKPM);
  assign rd_pm = RD && (ADDR == `SPC_OFF_CLKPM);
  assign host_rst_hits_ctx = hbr_s && !pme_s;

  // Supply request fields: PME context
  always @(posedge CLOCK) begin
    if (RST || host_rst_hits_ctx) begin
      core_req_reg <= `SPC_V_OFF;
      prog_req_reg <= `SPC_V_OFF;
    end else if (wr_sup) begin
      core_req_reg <= WDATA[`SPC_SUP_CORE_LSB+2:`SPC_SUP_CORE_LSB];
      prog_req_reg <= WDATA[`SPC_SUP_PROG_LSB+2:`SPC_SUP_PROG_LSB];
    end
  end

  // Ordinary control bits, cleared by either reset
  always @(posedge CLOCK) begin
    if (RST || hbr_s) begin
      stop_policy_reg <= 1'b0;
      ctl_enable_reg <= 1'b0;
      action_reg <= 1'b0;
      irq_mask_reg <= {`SPC_IRQ_W{1'b0}};
    end else begin
      if (wr_sup) begin
        stop_policy_reg <= WDATA[`SPC_SUP_STOP_POLICY];
      end
      if (wr_pm) begin
        ctl_enable_reg <= WDATA[`SPC_PM_CTL_ENABLE];
        action_reg <= WDATA[`SPC_PM_ACTION];
      end
      if (WR && (ADDR == `SPC_OFF_IRQ_MASK)) begin
        irq_mask_reg <= WDATA[`SPC_IRQ_W-1:0];
      end
    end
  end

  // Status bits, global reset only; set wins over read clear
  always @(posedge CLOCK) begin
    if (RST) begin
      access_seen_reg <= 1'b0;
      freq_changed_reg <= 1'b0;
    end else begin
      if (access_s) begin
        access_seen_reg <= 1'b1;
      end else if (rd_pm) begin
        access_seen_reg <= 1'b0;
      end
      freq_changed_reg <= CARD_CLK_SLOW_REQ;
    end
  end

  // Idle clock control
  wire stop_allowed;
  wire want_idle;
  assign stop_allowed = stop_policy_reg || host_stop_s;
  assign want_idle = ctl_enable_reg && idle_s && stop_allowed;
  always @(posedge CLOCK) begin
    if (RST) begin
      CARD_CLK_STOP_REQ <= 1'b0;
      CARD_CLK_SLOW_REQ <= 1'b0;
      CARD_CLK_EN <= 1'b0;
      div_reg <= 4'h0;
    end else begin
      CARD_CLK_STOP_REQ <= want_idle && !action_reg;
      CARD_CLK_SLOW_REQ <= want_idle && action_reg;
      div_reg <= div_reg + 4'h1;
      if (want_idle && action_reg) begin
        CARD_CLK_EN <= (div_reg == 4'h0);
      end else begin
        CARD_CLK_EN <= !(want_idle && !action_reg);
      end
    end
  end

  // Applied supply toward the power switch
  always @(posedge CLOCK) begin
    if (RST) begin
      core_app_reg <= `SPC_V_OFF;
      prog_app_reg <= `SPC_V_OFF;
      CORE_SUPPLY <= `SPC_V_OFF;
      PROG_SUPPLY <= `SPC_V_OFF;
      SUPPLY_UPDATE <= 1'b0;
    end else begin
      core_app_reg <= core_ok;
      prog_app_reg <= prog_ok;
      CORE_SUPPLY <= core_ok;
      PROG_SUPPLY <= prog_ok;
      SUPPLY_UPDATE <= (core_ok != core_app_reg) || (prog_ok != prog_app_reg);
    end
  end

  // Interrupt status, write one to clear, set wins
  assign irq_events = {SUPPLY_UPDATE, CARD_CLK_SLOW_REQ && !freq_changed_reg,
                       access_s && !access_seen_reg};
  always @(posedge CLOCK) begin
    if (RST) begin
      irq_status_reg <= {`SPC_IRQ_W{1'b0}};
      IRQ <= 1'b0;
    end else begin
      if (WR && (ADDR == `SPC_OFF_IRQ_STATUS)) begin
        irq_status_reg <= (irq_status_reg & ~WDATA[`SPC_IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
      IRQ <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (ADDR)
      `SPC_OFF_SUPPLY: begin
        rd_next[`SPC_SUP_FIXED_ONE] = 1'b1;
        rd_next[`SPC_SUP_STOP_POLICY] = stop_policy_reg;
        rd_next[`SPC_SUP_CORE_LSB+2:`SPC_SUP_CORE_LSB] = core_req_reg;
        rd_next[`SPC_SUP_PROG_LSB+2:`SPC_SUP_PROG_LSB] = prog_req_reg;
      end
      `SPC_OFF_CLKPM: begin
        rd_next[`SPC_PM_ACCESS_SEEN] = access_seen_reg;
        rd_next[`SPC_PM_FREQ_CHANGED] = freq_changed_reg;
        rd_next[`SPC_PM_CTL_ENABLE] = ctl_enable_reg;
        rd_next[`SPC_PM_ACTION] = action_reg;
      end
      `SPC_OFF_IRQ_STATUS: rd_next[`SPC_IRQ_W-1:0] = irq_status_reg;
      `SPC_OFF_IRQ_MASK: rd_next[`SPC_IRQ_W-1:0] = irq_mask_reg;
      `SPC_OFF_CARD_LIMIT: begin
        rd_next[3:0] = ok_s;
        rd_next[4] = present_s;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end
  always @(posedge CLOCK) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rd_next;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule

// ### testbench/spc_props.sv
`timescale 1ns/1ps
module spc_props (
  input wire CLOCK,
  input wire RST,
  input wire [7:0] ADDR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire CARD_PRESENT,
  input wire [2:0] CORE_SUPPLY,
  input wire [2:0] PROG_SUPPLY,
  input wire SUPPLY_UPDATE,
  input wire CARD_CLK_STOP_REQ,
  input wire CARD_CLK_SLOW_REQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data outside read slot");
  supply_fixed_a: assert property ($past(RD) && $past(ADDR) == 8'h10 |->
    RDATA[31:8] == 24'h00_0004 && !RDATA[3]) else $error("supply fixed bits wrong");
  pm_reserved_a: assert property ($past(RD) && $past(ADDR) == 8'h20 |->
    (RDATA & 32'hFCFE_FFFE) == 32'h0000_0000) else $error("pm reserved bits set");
  no_card_off_a: assert property (!CARD_PRESENT [*5] |->
    CORE_SUPPLY == 3'h0 && PROG_SUPPLY == 3'h0) else $error("supply without card");
  core_code_a: assert property (CORE_SUPPLY inside {3'h0, 3'h2, 3'h3, 3'h5})
    else $error("bad core supply code");
  prog_code_a: assert property (PROG_SUPPLY < 3'h6)
    else $error("bad program supply code");
  update_after_a: assert property ($changed(CORE_SUPPLY) || $changed(PROG_SUPPLY)
    |-> SUPPLY_UPDATE) else $error("missing supply update");
  update_cause_a: assert property (SUPPLY_UPDATE |->
    $changed(CORE_SUPPLY) || $changed(PROG_SUPPLY))
    else $error("spurious supply update");
  stop_or_slow_a: assert property (!(CARD_CLK_STOP_REQ && CARD_CLK_SLOW_REQ))
    else $error("stop and slow together");
endmodule
bind spc_socket_power_clock_ctrl spc_props chk (
  .CLOCK(CLOCK),
  .RST(RST),
  .ADDR(ADDR),
  .RD(RD),
  .RDATA(RDATA),
  .CARD_PRESENT(CARD_PRESENT),
  .CORE_SUPPLY(CORE_SUPPLY),
  .PROG_SUPPLY(PROG_SUPPLY),
  .SUPPLY_UPDATE(SUPPLY_UPDATE),
  .CARD_CLK_STOP_REQ(CARD_CLK_STOP_REQ),
  .CARD_CLK_SLOW_REQ(CARD_CLK_SLOW_REQ)
);

// ### testbench/spc_card_model.sv
`timescale 1ns/1ps
module spc_card_model (
  input wire CLOCK,
  input wire inserted,
  input wire [3:0] volts,
  input wire use_card,
  input wire [2:0] core_in,
  output reg present = 1'b0,
  output reg [3:0] volt_ok = 4'h0,
  output reg access = 1'b0,
  output reg idle = 1'b1
);
  // Card talks only while used and its core supply is on
  always @(posedge CLOCK) begin
    present <= inserted;
    volt_ok <= inserted ? volts : 4'h0;
    access <= use_card && core_in != 3'h0;
    idle <= !access;
  end
endmodule

// ### testbench/spc_socket_power_clock_ctrl_bench.sv
`timescale 1ns/1ps
module spc_socket_power_clock_ctrl_bench;
  reg CLOCK = 1'b0;
  reg RST = 1'b1;
  reg HOST_BUS_RESET = 1'b0;
  reg PME_ENABLE = 1'b0;
  reg [7:0] ADDR = 8'h00;
  reg [31:0] WDATA = 32'h0000_0000;
  reg WR = 1'b0;
  reg RD = 1'b0;
  reg HOST_CLKRUN_STOPPING = 1'b0;
  reg ins = 1'b0;
  reg [3:0] volts = 4'h0;
  reg use_card = 1'b0;
  wire CARD_PRESENT, CARD_ACCESS, CARD_IDLE, SUPPLY_UPDATE, IRQ;
  wire CARD_CLK_STOP_REQ, CARD_CLK_SLOW_REQ, CARD_CLK_EN;
  wire [3:0] CARD_VOLT_OK;
  wire [2:0] CORE_SUPPLY, PROG_SUPPLY;
  wire [31:0] RDATA;
  integer bad_count = 0;
  integer checks_done = 0;
  integer i;
  integer n_en;
  spc_socket_power_clock_ctrl DUT (.CLOCK(CLOCK), .RST(RST), .HOST_BUS_RESET(HOST_BUS_RESET),
    .PME_ENABLE(PME_ENABLE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CARD_PRESENT(CARD_PRESENT), .CARD_VOLT_OK(CARD_VOLT_OK), .CARD_ACCESS(CARD_ACCESS),
    .CARD_IDLE(CARD_IDLE), .HOST_CLKRUN_STOPPING(HOST_CLKRUN_STOPPING),
    .CORE_SUPPLY(CORE_SUPPLY), .PROG_SUPPLY(PROG_SUPPLY), .SUPPLY_UPDATE(SUPPLY_UPDATE),
    .CARD_CLK_STOP_REQ(CARD_CLK_STOP_REQ), .CARD_CLK_SLOW_REQ(CARD_CLK_SLOW_REQ),
    .CARD_CLK_EN(CARD_CLK_EN), .IRQ(IRQ));
  spc_card_model card (.CLOCK(CLOCK), .inserted(ins), .volts(volts), .use_card(use_card),
    .core_in(CORE_SUPPLY), .present(CARD_PRESENT), .volt_ok(CARD_VOLT_OK),
    .access(CARD_ACCESS), .idle(CARD_IDLE));
  initial forever #5 CLOCK = ~CLOCK;
  task cyc(input integer n);
    repeat (n) @(negedge CLOCK);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr32(input [7:0] a, input [31:0] d);
    begin
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      @(negedge CLOCK);
      chk(RDATA, exp);
    end
  endtask
  task hreset(input p);
    begin
      PME_ENABLE <= p;
      cyc(4);
      HOST_BUS_RESET <= 1'b1;
      cyc(4);
      HOST_BUS_RESET <= 1'b0;
      cyc(6);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge CLOCK);
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    rd_chk(8'h10, 32'h0000_0400);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h44, 32'h0000_0000);
    wr32(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_04F7);
    ins <= 1'b1;
    volts <= 4'hF;
    for (i = 0; i < 8; i = i + 1) begin
      wr32(8'h10, {25'h0, i[2:0], 1'b0, i[2:0]});
      rd_chk(8'h10, 32'h0000_0400 | (i << 4) | i);
      cyc(6);
      chk(PROG_SUPPLY, i < 6 ? i : 0);
      chk(CORE_SUPPLY, (i == 1 || i == 4 || i > 5) ? 0 : i);
    end
    volts <= 4'h1;
    wr32(8'h10, 32'h0000_0033);
    cyc(6);
    chk({CORE_SUPPLY, PROG_SUPPLY}, 6'h00);
    wr32(8'h10, 32'h0000_0021);
    cyc(6);
    chk({CORE_SUPPLY, PROG_SUPPLY}, 6'h11);
    ins <= 1'b0;
    cyc(6);
    chk({CORE_SUPPLY, PROG_SUPPLY}, 6'h00);
    ins <= 1'b1;
    cyc(6);
    chk({CORE_SUPPLY, PROG_SUPPLY}, 6'h11);
    wr32(8'h34, 32'h0000_0001);
    wr32(8'h30, 32'h0000_0007);
    cyc(2);
    chk(IRQ, 0);
    use_card <= 1'b1;
    cyc(1);
    use_card <= 1'b0;
    cyc(8);
    chk(IRQ, 1);
    hreset(1'b1);
    chk(IRQ, 0);
    rd_chk(8'h20, 32'h0200_0000);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0421);
    rd_chk(8'h30, 32'h0000_0001);
    wr32(8'h30, 32'h0000_0001);
    rd_chk(8'h30, 32'h0000_0000);
    hreset(1'b0);
    rd_chk(8'h10, 32'h0000_0400);
    wr32(8'h10, 32'h0000_0080);
    wr32(8'h20, 32'h0001_0001);
    cyc(8);
    chk(CARD_CLK_SLOW_REQ, 1);
    rd_chk(8'h20, 32'h0101_0001);
    rd_chk(8'h30, 32'h0000_0006);
    n_en = 0;
    for (i = 0; i < 16; i = i + 1) begin
      cyc(1);
      n_en = n_en + CARD_CLK_EN;
    end
    chk(n_en, 1);
    wr32(8'h20, 32'h0001_0000);
    cyc(8);
    chk({CARD_CLK_STOP_REQ, CARD_CLK_EN}, 2'h2);
    wr32(8'h20, 32'h0000_0000);
    cyc(8);
    chk({CARD_CLK_STOP_REQ, CARD_CLK_EN}, 2'h1);
    wr32(8'h10, 32'h0000_0000);
    wr32(8'h20, 32'h0001_0000);
    cyc(8);
    chk(CARD_CLK_STOP_REQ, 0);
    HOST_CLKRUN_STOPPING <= 1'b1;
    cyc(8);
    chk(CARD_CLK_STOP_REQ, 1);
    end_sim;
  end
endmodule
